// ---- inc/port_status_pkg.sv ----
// Package with register map, field positions and link-state types of the port status block.
package port_status_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index.
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_P1_STAT0 = 10'h01E;
    localparam logic [9:0] IDX_P1_STAT1 = 10'h01F;
    localparam logic [9:0] IDX_P2_STAT0 = 10'h02E;
    localparam logic [9:0] IDX_P2_STAT1 = 10'h02F;
    localparam logic [9:0] IDX_P3_STAT0 = 10'h03E;
    localparam logic [9:0] IDX_P3_STAT1 = 10'h03F;
    localparam logic [9:0] IDX_RESET_CTRL = 10'h043;
    localparam logic [9:0] IDX_RATE_BASE = 10'h0E0;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h0F0;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0F1;

    // ------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------
    localparam int BIT_PARTNER_10H = 0;
    localparam int BIT_XOVER_SEL = 7;
    localparam int BIT_POL_REV = 5;
    localparam int BIT_TX_PAUSE = 4;
    localparam int BIT_RX_PAUSE = 3;
    localparam int BIT_SPEED = 2;
    localparam int BIT_DUPLEX = 1;
    localparam int BIT_FAR_FAULT = 0;
    localparam int BIT_SOFT_RESET = 4;
    localparam int BIT_PCS_RESET = 0;
    localparam int IRQ_BIT_FAULT = 3;

    // ------------------------------------------------------------
    // Reset values and sizes.
    // ------------------------------------------------------------
    localparam logic XOVER_RESET = 1'b1;
    localparam logic [7:0] RESET_CTRL_RSVD = 8'hE0;
    localparam int NUM_PORTS = 3;
    localparam int PHY_PORT = 1;
    localparam int NUM_RATE = 6;
    localparam int IRQ_W = 4;

    // ------------------------------------------------------------
    // Rate-limit encoding.
    // ------------------------------------------------------------
    localparam logic [6:0] RATE_MAX_100 = 7'h63;
    localparam logic [6:0] RATE_MAX_10 = 7'h09;
    localparam logic [6:0] RATE_SUB_BASE = 7'h64;
    localparam logic [6:0] RATE_SUB_MAX = 7'h73;
    localparam logic [16:0] KBPS_PER_MBPS = 17'h003E8;
    localparam logic [16:0] KBPS_SUB_STEP = 17'h00040;
    localparam logic [16:0] KBPS_FULL_100 = 17'h186A0;
    localparam logic [16:0] KBPS_FULL_10 = 17'h02710;

    // Live state of one port as seen by the MAC/PHY.
    typedef struct packed {
        logic partner_10h;
        logic pol_rev;
        logic tx_pause;
        logic rx_pause;
        logic speed100;
        logic full_duplex;
        logic far_fault;
    } link_t;

endpackage

// ---- core/port_status_reset_ratelimit.sv ----
// Port link status, chip reset control and rate-limit decode behind a Wishbone slave.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Status0 bit0 shows partner 10BT half-duplex.
// - Bit7 selects crossover scheme, resets one.
// - Bit5 shows reversed polarity, copper port only.
// - Bit4 shows transmit pause active.
// - Bit3 shows receive pause active.
// - Bit2 shows speed, one for 100.
// - Bit1 shows duplex, one for full.
// - Bit0 shows far-end fault, port two only.
// - Reset bit4 restores all registers to defaults.
// - Reset bit0 resets the coding sublayer.
// - Rate limit code is seven bits wide.
// - At 100, codes 1..0x63 give Mbps.
// - At 100, codes 0, 0x64 give full.
// - At 10, codes 1..9 give Mbps.
// - At 10, codes 0, 0x0A give full.
module port_status_reset_ratelimit
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Live link state, index 0 is port 1
    input wire port_status_pkg::link_t [port_status_pkg::NUM_PORTS-1:0] link_state,
    // Controls to the port logic
    output logic crossover_algorithm_select,
    output logic soft_reset,
    output logic pcs_reset,
    output logic [port_status_pkg::NUM_PORTS-1:0][16:0] ingress_kbps,
    output logic [port_status_pkg::NUM_PORTS-1:0][16:0] egress_kbps,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [port_status_pkg::NUM_PORTS-1:0][7:0] stat1;
        logic [port_status_pkg::NUM_PORTS-1:0] stat0;
        logic [port_status_pkg::NUM_PORTS-1:0] xover;
        logic soft_pulse;
        logic pcs;
        logic [port_status_pkg::NUM_RATE-1:0][6:0] rate_code;
        logic [port_status_pkg::NUM_RATE-1:0][16:0] rate_kbps;
        logic [port_status_pkg::IRQ_W-1:0] irq_status;
        logic [port_status_pkg::IRQ_W-1:0] irq_mask;
        logic irq;
    } state_t;

    state_t s;
    state_t next_s;
    logic [1:0] rst_sync;
    logic rst_n;

    // ------------------------------------------------------------
    // Reset release.
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ------------------------------------------------------------
    // Rate-limit decode.
    // ------------------------------------------------------------
    // Codes that name no limit at the current speed fall back to full rate,
    // so a stale 100 Mbps code never throttles a 10 Mbps link to zero.
    function automatic logic [16:0] decode_rate(input logic [6:0] code, input logic fast);
        logic [16:0] full;
        logic [6:0] top;
        if (fast)
        begin
            full = port_status_pkg::KBPS_FULL_100;
            top = port_status_pkg::RATE_MAX_100;
        end
        else
        begin
            full = port_status_pkg::KBPS_FULL_10;
            top = port_status_pkg::RATE_MAX_10;
        end

        // Sub-megabit codes mean the same at both speeds.
        if (code > port_status_pkg::RATE_SUB_BASE && code <= port_status_pkg::RATE_SUB_MAX)
        begin
            decode_rate = 17'(code - port_status_pkg::RATE_SUB_BASE)
                * port_status_pkg::KBPS_SUB_STEP;
        end
        else if (code != 7'h00 && code <= top)
        begin
            decode_rate = 17'(code) * port_status_pkg::KBPS_PER_MBPS;
        end
        else
        begin
            decode_rate = full;
        end
    endfunction

    // ------------------------------------------------------------
    // Reset value.
    // ------------------------------------------------------------
    function automatic state_t reset_state();
        state_t r;
        r = '0;
        r.xover = {port_status_pkg::NUM_PORTS{port_status_pkg::XOVER_RESET}};
        for (int i = 0; i < port_status_pkg::NUM_RATE; i++)
        begin
            r.rate_kbps[i] = port_status_pkg::KBPS_FULL_10;
        end
        reset_state = r;
    endfunction

    // ------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------
    always_comb
    begin
        logic req;
        logic wr;
        logic [9:0] idx;
        logic [7:0] wbyte;
        logic [7:0] rbyte;
        logic [7:0] live;
        logic [port_status_pkg::IRQ_W-1:0] events;
        logic [port_status_pkg::IRQ_W-1:0] clr;
        req = 1'b0;
        wr = 1'b0;
        idx = 10'h000;
        wbyte = 8'h00;
        rbyte = 8'h00;
        live = 8'h00;
        events = '0;
        clr = '0;
        next_s = s;

        // ------------------------------------------------------------
        // Software reset.
        // ------------------------------------------------------------
        // A software reset restores every register but leaves the bus answer alone.
        // No strap values live in this block, so nothing is held back.
        if (s.soft_pulse)
        begin
            next_s = reset_state();
            next_s.ack = s.ack;
            next_s.rdata = s.rdata;
        end

        // ------------------------------------------------------------
        // Live status.
        // ------------------------------------------------------------
        // Live status is sampled every cycle; no write path reaches it.
        for (int p = 0; p < port_status_pkg::NUM_PORTS; p++)
        begin
            live = 8'h00;
            live[port_status_pkg::BIT_TX_PAUSE] = link_state[p].tx_pause;
            live[port_status_pkg::BIT_RX_PAUSE] = link_state[p].rx_pause;
            live[port_status_pkg::BIT_SPEED] = link_state[p].speed100;
            live[port_status_pkg::BIT_DUPLEX] = link_state[p].full_duplex;
            if (p == port_status_pkg::PHY_PORT)
            begin
                live[port_status_pkg::BIT_POL_REV] = link_state[p].pol_rev;
                live[port_status_pkg::BIT_FAR_FAULT] = link_state[p].far_fault;
            end
            next_s.stat1[p] = live;
            next_s.stat0[p] = link_state[p].partner_10h;
            if (live != s.stat1[p])
            begin
                events[p] = 1'b1;
            end
        end
        events[port_status_pkg::IRQ_BIT_FAULT] =
            link_state[port_status_pkg::PHY_PORT].far_fault
            & ~s.stat1[port_status_pkg::PHY_PORT][port_status_pkg::BIT_FAR_FAULT];

        // ------------------------------------------------------------
        // Rate limits.
        // ------------------------------------------------------------
        // Rate limits follow the live speed of their own port, so a speed change
        // takes effect one cycle later without software help.
        for (int r = 0; r < port_status_pkg::NUM_RATE; r++)
        begin
            next_s.rate_kbps[r] = decode_rate(next_s.rate_code[r],
                link_state[r / 2].speed100);
        end

        // Soft reset pulse clears itself after one cycle.
        next_s.soft_pulse = 1'b0;

        // ------------------------------------------------------------
        // Bus access.
        // ------------------------------------------------------------
        // One cycle to answer, ack dropped the cycle after.
        req = wb_cyc_i & wb_stb_i & ~s.ack;
        wr = req & wb_we_i & wb_sel_i[0];
        idx = wb_adr_i[11:2];
        wbyte = wb_dat_i[7:0];
        next_s.ack = req;

        // ------------------------------------------------------------
        // Read multiplexer.
        // ------------------------------------------------------------
        case (idx)
            port_status_pkg::IDX_P1_STAT0:
            begin
                rbyte = {7'h00, s.stat0[0]};
            end

            port_status_pkg::IDX_P2_STAT0:
            begin
                rbyte = {7'h00, s.stat0[1]};
            end

            port_status_pkg::IDX_P3_STAT0:
            begin
                rbyte = {7'h00, s.stat0[2]};
            end

            port_status_pkg::IDX_P1_STAT1:
            begin
                rbyte = {s.xover[0], s.stat1[0][6:0]};
            end

            port_status_pkg::IDX_P2_STAT1:
            begin
                rbyte = {s.xover[1], s.stat1[1][6:0]};
            end

            port_status_pkg::IDX_P3_STAT1:
            begin
                rbyte = {s.xover[2], s.stat1[2][6:0]};
            end

            // The soft reset bit is a strobe and always reads back as zero.
            port_status_pkg::IDX_RESET_CTRL:
            begin
                rbyte = port_status_pkg::RESET_CTRL_RSVD | {7'h00, s.pcs};
            end

            port_status_pkg::IDX_IRQ_STATUS:
            begin
                rbyte = {4'h0, s.irq_status};
            end

            port_status_pkg::IDX_IRQ_MASK:
            begin
                rbyte = {4'h0, s.irq_mask};
            end

            default:
            begin
                rbyte = 8'h00;
                for (int r = 0; r < port_status_pkg::NUM_RATE; r++)
                begin
                    if (idx == port_status_pkg::IDX_RATE_BASE + 10'(r))
                    begin
                        rbyte = {1'b0, s.rate_code[r]};
                    end
                end
            end
        endcase

        // Read data is held until the next read, so a slow master still finds it.
        if (req && !wb_we_i)
        begin
            next_s.rdata = {24'h000000, rbyte};
        end

        // ------------------------------------------------------------
        // Register writes.
        // ------------------------------------------------------------
        // Only the low byte lane carries data, so a write without sel[0] is dropped.
        if (wr)
        begin
            case (idx)
                port_status_pkg::IDX_P1_STAT1:
                begin
                    next_s.xover[0] = wbyte[port_status_pkg::BIT_XOVER_SEL];
                end

                port_status_pkg::IDX_P2_STAT1:
                begin
                    next_s.xover[1] = wbyte[port_status_pkg::BIT_XOVER_SEL];
                end

                port_status_pkg::IDX_P3_STAT1:
                begin
                    next_s.xover[2] = wbyte[port_status_pkg::BIT_XOVER_SEL];
                end

                port_status_pkg::IDX_RESET_CTRL:
                begin
                    next_s.soft_pulse = wbyte[port_status_pkg::BIT_SOFT_RESET];
                    next_s.pcs = wbyte[port_status_pkg::BIT_PCS_RESET];
                end

                port_status_pkg::IDX_IRQ_STATUS:
                begin
                    clr = wbyte[port_status_pkg::IRQ_W-1:0];
                end

                port_status_pkg::IDX_IRQ_MASK:
                begin
                    next_s.irq_mask = wbyte[port_status_pkg::IRQ_W-1:0];
                end

                default:
                begin
                    for (int r = 0; r < port_status_pkg::NUM_RATE; r++)
                    begin
                        if (idx == port_status_pkg::IDX_RATE_BASE + 10'(r))
                        begin
                            next_s.rate_code[r] = wbyte[6:0];
                        end
                    end
                end
            endcase
        end

        // ------------------------------------------------------------
        // Interrupts.
        // ------------------------------------------------------------
        // An event in the clearing cycle survives the clear.
        next_s.irq_status = (next_s.irq_status & ~clr) | events;
        next_s.irq = |(next_s.irq_status & next_s.irq_mask);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= reset_state();
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;
    assign crossover_algorithm_select = s.xover[port_status_pkg::PHY_PORT];
    assign soft_reset = s.soft_pulse;
    assign pcs_reset = s.pcs;
    assign irq = s.irq;
    always_comb
    begin
        for (int p = 0; p < port_status_pkg::NUM_PORTS; p++)
        begin
            ingress_kbps[p] = s.rate_kbps[2 * p];
            egress_kbps[p] = s.rate_kbps[2 * p + 1];
        end
    end

endmodule

// ---- tb/port_status_props.sv ----
// Concurrent checks on the port status block, seen from its top-level ports.
`timescale 1ns/1ps
module port_status_props
(
    // Clock, reset and register bus
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Link state and controls
    input wire port_status_pkg::link_t [port_status_pkg::NUM_PORTS-1:0] link_state,
    input wire logic crossover_algorithm_select,
    input wire logic soft_reset,
    input wire logic pcs_reset,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic wr_rst;
    logic rd;
    // The write is taken at the edge where the request stands and ack is still low.
    assign wr_rst = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 12'h10C
        && wb_sel_i[0];
    assign rd = wb_ack_o && !wb_we_i;
    property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_soft_pulse; soft_reset |=> !soft_reset; endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset too long");
    property p_soft_cause; soft_reset |-> $past(wr_rst && wb_dat_i[4]); endproperty
    a_soft_cause: assert property (p_soft_cause) else $error("soft reset uncaused");
    property p_soft_restore;
        soft_reset |-> ##[1:2] (crossover_algorithm_select && !pcs_reset);
    endproperty
    a_soft_restore: assert property (p_soft_restore) else $error("no restore");
    property p_pcs_set; wr_rst && wb_dat_i[0] && !wb_dat_i[4] |-> ##[1:2] pcs_reset; endproperty
    a_pcs_set: assert property (p_pcs_set) else $error("pcs not set");
    property p_rd_upper; rd |-> wb_dat_o[31:8] == 24'h000000; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
    property p_mii_bits;
        rd && (wb_adr_i == 12'h07C || wb_adr_i == 12'h0FC) |-> wb_dat_o[6:5] == 2'b00 && !wb_dat_o[0];
    endproperty
    a_mii_bits: assert property (p_mii_bits) else $error("copper bits on mii port");
    property p_live; rd && wb_adr_i == 12'h0BC |-> wb_dat_o[5:0] == 6'($past(link_state[1], 2)); endproperty
    a_live: assert property (p_live) else $error("status not live");
    c_soft: cover property (soft_reset);
    c_pcs: cover property (pcs_reset);
    c_irq: cover property (irq);
endmodule

// ---- tb/port_status_reset_ratelimit_tb_top.sv ----
// Self-checking bench for the port status, reset control and rate-limit block.
`timescale 1ns/1ps
module port_status_reset_ratelimit_tb_top;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'hF;
    logic [31:0] wd = 32'h00000000;
    logic [31:0] rdat;
    logic ack;
    port_status_pkg::link_t [2:0] link = '0;
    logic xo;
    logic srst;
    logic pcs;
    logic [2:0][16:0] ing;
    logic [2:0][16:0] egr;
    logic irq;
    logic seen = 1'b0;
    logic [31:0] q;
    int n_errors = 0;
    int n_tests = 0;
    port_status_reset_ratelimit i_dut (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(rdat), .wb_ack_o(ack), .link_state(link), .crossover_algorithm_select(xo),
        .soft_reset(srst), .pcs_reset(pcs), .ingress_kbps(ing), .egress_kbps(egr), .irq(irq));
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (srst === 1'b1) seen <= 1'b1;
    task wrap_up;
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One classic cycle; the request stands until ack is sampled high.
    task bus(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        wd <= {24'h0, d};
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
        begin
            n_errors++;
            wrap_up();
        end
    endtask
    task wr(input logic [9:0] idx, input logic [7:0] d); bus(1'b1, idx, d, 4'hF); endtask
    task rdc(input logic [9:0] idx, input logic [7:0] e); bus(1'b0, idx, 8'h00, 4'hF); chk(q, {24'h0, e}); endtask
    task wt(input int n); repeat (n) @(posedge ref_clk); endtask
    function automatic logic [16:0] kb(input logic [6:0] c, input logic s);
        if (c >= 7'h65 && c <= 7'h73) return 17'((c - 7'h64) * 64);
        if (c >= 7'h01 && c <= (s ? 7'h63 : 7'h09)) return 17'(c * 1000);
        return s ? 17'h186A0 : 17'h02710;
    endfunction
    task t_reset_vals;
        chk(xo, 1);
        rdc(10'h01F, 8'h80);
        rdc(10'h02F, 8'h80);
        rdc(10'h043, 8'hE0);
        rdc(10'h01E, 8'h00);
        chk(ing[1], 17'h02710);
    endtask
    task t_unmapped;
        rdc(10'h200, 8'h00);
        bus(1'b1, 10'h0E2, 8'h7F, 4'hE);
        rdc(10'h0E2, 8'h00);
    endtask
    task t_irq;
        wr(10'h0F0, 8'h0F);
        link[1] <= 7'h01;
        wt(4);
        chk(irq, 0);
        rdc(10'h0F0, 8'h0A);
        wr(10'h0F1, 8'h02); wt(2); chk(irq, 1);
        wr(10'h0F0, 8'h02); wt(2); chk(irq, 0);
        wr(10'h0F1, 8'h08); wt(2); chk(irq, 1);
        wr(10'h0F0, 8'h08); wt(2); chk(irq, 0);
    endtask
    task t_live;
        link <= {7'h00, 7'h7F, 7'h7F};
        wt(4);
        rdc(10'h02F, 8'hBF);
        rdc(10'h01F, 8'h9E);
        rdc(10'h03F, 8'h80);
        bus(1'b0, 10'h01E, 8'h00, 4'hF); chk(q[0], 1);
        wr(10'h02F, 8'h40);
        rdc(10'h02F, 8'h3F);
        chk(xo, 0);
    endtask
    task t_rate;
        logic [6:0] codes [8] = '{7'h00, 7'h01, 7'h09, 7'h0A, 7'h63, 7'h64, 7'h65, 7'h73};
        for (int s = 1; s >= 0; s--)
        begin
            link[1].speed100 <= s[0];
            foreach (codes[i])
            begin
                wr(10'h0E2, {1'b0, codes[i]}); wt(2);
                chk(ing[1], kb(codes[i], s[0]));
            end
        end
        wr(10'h0E3, 8'h05); wt(2); chk(egr[1], 17'h01388);
        wr(10'h0E0, 8'h73); wt(2); chk(ing[0], 17'h003C0);
    endtask
    task t_soft;
        wr(10'h043, 8'h01); wt(2); chk(pcs, 1);
        wr(10'h0F1, 8'h0F);
        wr(10'h043, 8'h11);
        wt(3);
        chk(seen, 1);
        chk(xo, 1);
        chk(pcs, 0);
        chk(ing[0], 17'h186A0);
        rdc(10'h0F1, 8'h00);
        rdc(10'h043, 8'hE0);
    endtask
    initial
    begin
        wt(3);
        resetn <= 1'b1;
        wt(4);
        t_reset_vals();
        t_unmapped();
        t_irq();
        t_live();
        t_rate();
        t_soft();
        wrap_up();
    end
endmodule
bind port_status_reset_ratelimit port_status_props i_props (.ref_clk(ref_clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .link_state(link_state), .crossover_algorithm_select(crossover_algorithm_select),
    .soft_reset(soft_reset), .pcs_reset(pcs_reset), .irq(irq));
